// File: common/pll_ctrl_map.svh
// Register offsets, field positions, reset values and counts of the loop control block
`ifndef PLL_CTRL_MAP_SVH
`define PLL_CTRL_MAP_SVH

// ============================================================
// Register byte offsets (one 32-bit word each)
`define LOOP_CTRL_OFS   5'h00
`define BW_CTRL_OFS     5'h04
`define CFG_TWO_OFS     5'h08
`define IRQ_STAT_OFS    5'h0c
`define IRQ_MASK_OFS    5'h10

// ============================================================
// Field positions
`define LC_IE_BIT       7
`define LC_FLAG_BIT     6
`define LC_PWR_BIT      5
`define LC_BCS_BIT      4
`define BW_AUTO_BIT     7
`define BW_LOCK_BIT     6
`define CFG_OSC_BIT     0
`define ST_LOCK_BIT     0
`define ST_SWITCH_BIT   1

// ============================================================
// Reset values
`define LC_PWR_RST      1'b1
`define ST_RST          2'h0
`define RD_ZERO         8'h00

// ============================================================
// Source edges counted on each side during a base clock switch
`define SWITCH_EDGES    2'h3

`endif

// File: common/pll_ctrl_pkg.sv
// Types shared by the loop control block
package pll_ctrl_pkg;

	// Base clock selector states
	typedef enum logic [0:0] {
		SW_RUN  = 1'b0,
		SW_HOLD = 1'b1
	} sw_state_t;

endpackage

// File: rtl/base_clock_switch.sv
// Glitch-free base clock source selector with divide by two
`include "pll_ctrl_map.svh"

module base_clock_switch (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Source select and sampled clocks
	input  wire logic select_i,
	input  wire logic xtal_i,
	input  wire logic vco_i,
	// Divided output and status
	output logic      base_clk_o,
	output logic      busy_o,
	output logic      done_o
);

	pll_ctrl_pkg::sw_state_t state_r;
	logic       xp_r;
	logic       vp_r;
	logic       cur_r;
	logic [1:0] xcnt_r;
	logic [1:0] vcnt_r;
	logic       xe;
	logic       ve;

	assign xe     = xtal_i & ~xp_r;
	assign ve     = vco_i & ~vp_r;
	assign busy_o = (state_r == pll_ctrl_pkg::SW_HOLD);

	always_ff @(posedge clk_i) begin
		xp_r <= rst_i ? 1'b0 : xtal_i;
		vp_r <= rst_i ? 1'b0 : vco_i;
	end

	// ============================================================
	// Hold the output while both sources settle; a stopped source stalls the switch
	always_ff @(posedge clk_i) begin
		done_o <= 1'b0;
		if (rst_i) begin
			state_r <= pll_ctrl_pkg::SW_RUN;
			cur_r   <= 1'b0;
			xcnt_r  <= 2'h0;
			vcnt_r  <= 2'h0;
		end else begin
			unique case (state_r)
				pll_ctrl_pkg::SW_RUN: begin
					xcnt_r <= 2'h0;
					vcnt_r <= 2'h0;
					if (select_i != cur_r)
						state_r <= pll_ctrl_pkg::SW_HOLD;
				end
				pll_ctrl_pkg::SW_HOLD: begin
					if (xe && xcnt_r != `SWITCH_EDGES)
						xcnt_r <= xcnt_r + 2'h1;
					if (ve && vcnt_r != `SWITCH_EDGES)
						vcnt_r <= vcnt_r + 2'h1;
					if (xcnt_r == `SWITCH_EDGES && vcnt_r == `SWITCH_EDGES) begin
						cur_r   <= select_i;
						done_o  <= 1'b1;
						state_r <= pll_ctrl_pkg::SW_RUN;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			base_clk_o <= 1'b0;
		else if (!busy_o && (cur_r ? ve : xe))
			base_clk_o <= ~base_clk_o;
	end

	a_switch_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		busy_o |=> $stable(base_clk_o))
		else $error("base clock moved during source switch");

endmodule // base_clock_switch

// File: rtl/pll_lock_irq_and_lowpower_ctrl.sv
// Loop lock interrupt, low-power gating and register slave of the clock generator
//
// Chosen here: the address map and register access over Avalon-MM.
`include "pll_ctrl_map.svh"

// ============================================================
// What this block does
// - With automatic bandwidth on, every lock change raises a loop interrupt request; here a change in the first cycle after it turns on is missed
// - Loop requests reach the CPU only while loop_irq_enable is set
// - loop_irq_flag sets on every lock change whatever the enable holds
// - Automatic bandwidth off blocks loop interrupts; loop_irq_flag reads zero
// - Setting base_clock_select is accepted even while lock reads zero
// - Wait leaves the clock generator untouched; only software writes change it
// - Lock change interrupt can wake the processor from wait
// - Stop without osc_run_in_stop: oscillator, loop off; clocks, interrupt low
// - Stop with osc_run_in_stop: loop off, oscillator keeps running
// - In break with clear enable one, cleared status bits stay cleared
// - In break with clear enable zero, register access keeps loop_irq_flag
// - Lock reads zero without automatic mode, else read-only live lock state
// - loop_power_on cannot be cleared while base_clock_select is set
// - A source switch holds the base clock static for three edges each

module pll_lock_irq_and_lowpower_ctrl (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Avalon-MM slave
	input  wire logic [4:0]  address_i,
	input  wire logic        read_i,
	input  wire logic        write_i,
	input  wire logic [3:0]  byteenable_i,
	input  wire logic [31:0] writedata_i,
	output logic      [31:0] readdata_o,
	output logic             waitrequest_o,
	// Analog loop and oscillator
	input  wire logic        lock_raw_i,
	input  wire logic        crystal_clock_i,
	input  wire logic        vco_clock_i,
	output logic             loop_enable_o,
	output logic             osc_enable_o,
	output logic             crystal_clock_o,
	output logic             base_clock_out_o,
	// Low power and break control
	input  wire logic        stop_i,
	input  wire logic        break_i,
	input  wire logic        break_flag_clear_enable_i,
	// Interrupts
	output logic             clockgen_irq_out_o,
	output logic             irq_o
);

	// ============================================================
	// Decode
	function automatic logic hit(input logic [4:0] addr, input logic [4:0] ofs);
		hit = (addr == ofs);
	endfunction

	logic       ack_r;
	logic       take_wr;
	logic       take_rd;
	logic [7:0] wd;
	logic       wr_ctrl;
	logic       wr_bw;
	logic       wr_cfg;
	logic       wr_stat;
	logic       wr_mask;
	logic       rd_ctrl;
	logic       protect;

	assign waitrequest_o = (read_i | write_i) & ~ack_r;
	assign take_wr       = write_i & ack_r & byteenable_i[0];
	assign take_rd       = read_i & ack_r;
	assign wd            = writedata_i[7:0];
	assign wr_ctrl       = take_wr & hit(address_i, `LOOP_CTRL_OFS);
	assign wr_bw         = take_wr & hit(address_i, `BW_CTRL_OFS);
	assign wr_cfg        = take_wr & hit(address_i, `CFG_TWO_OFS);
	assign wr_stat       = take_wr & hit(address_i, `IRQ_STAT_OFS);
	assign wr_mask       = take_wr & hit(address_i, `IRQ_MASK_OFS);
	assign rd_ctrl       = take_rd & hit(address_i, `LOOP_CTRL_OFS);
	// Break with clear enable low freezes software clears
	assign protect       = break_i & ~break_flag_clear_enable_i;

	// One wait state: read data is captured, then presented with waitrequest low
	always_ff @(posedge clk_i) begin
		if (rst_i)
			ack_r <= 1'b0;
		else
			ack_r <= (read_i | write_i) & ~ack_r;
	end

	// ============================================================
	// Control registers
	logic ie_r;
	logic pwr_r;
	logic bcs_r;
	logic auto_r;
	logic auto_d_r;
	logic lock_d_r;
	logic flag_r;
	logic osc_run_r;
	logic cfg_done_r;
	logic lock_evt;
	logic lock_seen;

	// Lock is only meaningful in automatic mode
	assign lock_seen = auto_r & lock_raw_i;
	// Change seen only once automatic mode has settled for a cycle
	assign lock_evt  = auto_r & auto_d_r & (lock_raw_i != lock_d_r);

	// Stop and wait inputs never reach these; only writes do
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ie_r  <= 1'b0;
			pwr_r <= `LC_PWR_RST;
			bcs_r <= 1'b0;
		end else if (wr_ctrl) begin
			ie_r  <= wd[`LC_IE_BIT];
			// Lock state is not consulted here
			bcs_r <= wd[`LC_BCS_BIT] & pwr_r;
			pwr_r <= wd[`LC_PWR_BIT] | bcs_r;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			auto_r   <= 1'b0;
			auto_d_r <= 1'b0;
			lock_d_r <= 1'b0;
		end else begin
			if (wr_bw)
				auto_r <= wd[`BW_AUTO_BIT];
			auto_d_r <= auto_r;
			lock_d_r <= lock_raw_i;
		end
	end

	// Set wins over clear; only a flag the reader actually saw is cleared
	always_ff @(posedge clk_i) begin
		if (rst_i)
			flag_r <= 1'b0;
		else if (lock_evt)
			flag_r <= 1'b1;
		else if (rd_ctrl && readdata_o[`LC_FLAG_BIT] && !protect)
			flag_r <= 1'b0;
	end

	// Configuration bit takes one write per reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			osc_run_r  <= 1'b0;
			cfg_done_r <= 1'b0;
		end else if (wr_cfg && !cfg_done_r) begin
			osc_run_r  <= wd[`CFG_OSC_BIT];
			cfg_done_r <= 1'b1;
		end
	end

	// ============================================================
	// Sticky status, mask and system interrupt
	logic [1:0] st_r;
	logic [1:0] mask_r;
	logic [1:0] st_evt;
	logic [1:0] st_clr;
	logic       sw_done;

	assign st_evt = {sw_done, lock_evt};
	assign st_clr = (wr_stat && !protect) ? wd[1:0] : 2'h0;

	always_ff @(posedge clk_i) begin
		if (rst_i)
			st_r <= `ST_RST;
		else
			st_r <= (st_r & ~st_clr) | st_evt;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			mask_r <= 2'h0;
		else if (wr_mask)
			mask_r <= wd[1:0];
	end

	// ============================================================
	// Read mux, captured while waitrequest is high
	logic [7:0] rd_byte;

	always_comb begin
		rd_byte = `RD_ZERO;
		if (hit(address_i, `LOOP_CTRL_OFS)) begin
			rd_byte[`LC_IE_BIT]   = ie_r;
			rd_byte[`LC_FLAG_BIT] = flag_r & auto_r;
			rd_byte[`LC_PWR_BIT]  = pwr_r;
			rd_byte[`LC_BCS_BIT]  = bcs_r;
		end else if (hit(address_i, `BW_CTRL_OFS)) begin
			rd_byte[`BW_AUTO_BIT] = auto_r;
			rd_byte[`BW_LOCK_BIT] = lock_seen;
		end else if (hit(address_i, `CFG_TWO_OFS)) begin
			rd_byte[`CFG_OSC_BIT] = osc_run_r;
		end else if (hit(address_i, `IRQ_STAT_OFS)) begin
			rd_byte[1:0] = st_r;
		end else if (hit(address_i, `IRQ_MASK_OFS)) begin
			rd_byte[1:0] = mask_r;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			readdata_o <= 32'h0;
		else if (read_i && !ack_r)
			readdata_o <= {24'h0, rd_byte};
	end

	// ============================================================
	// Low-power gating of oscillator, loop and outputs
	logic osc_on;
	logic loop_on;
	logic sw_base;
	logic sw_busy;

	assign osc_on        = ~stop_i | osc_run_r;
	assign loop_on       = pwr_r & ~stop_i;
	assign osc_enable_o  = osc_on;
	assign loop_enable_o = loop_on;

	base_clock_switch u_switch (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.select_i   (bcs_r),
		.xtal_i     (crystal_clock_i & osc_on),
		.vco_i      (vco_clock_i & loop_on),
		.base_clk_o (sw_base),
		.busy_o     (sw_busy),
		.done_o     (sw_done)
	);

	// Outputs go low in stop unless the oscillator is kept alive
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			crystal_clock_o  <= 1'b0;
			base_clock_out_o <= 1'b0;
		end else begin
			crystal_clock_o  <= crystal_clock_i & osc_on;
			base_clock_out_o <= sw_base & osc_on;
		end
	end

	// Not gated by wait, so a lock change can wake the core
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clockgen_irq_out_o <= 1'b0;
			irq_o              <= 1'b0;
		end else begin
			clockgen_irq_out_o <= flag_r & ie_r & auto_r & osc_on;
			irq_o              <= |(st_r & mask_r);
		end
	end

	// ============================================================
	// Assertions
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_lock_sets_flag: assert property (
		lock_evt |=> flag_r ##1 (clockgen_irq_out_o || !$past(ie_r && auto_r && osc_on)))
		else $error("lock change did not raise the loop flag");

	a_flag_no_enable: assert property (
		(lock_evt && !ie_r) |=> flag_r && st_r[`ST_LOCK_BIT])
		else $error("flag not set with interrupt disabled");

	a_irq_needs_en: assert property (
		clockgen_irq_out_o |-> $past(ie_r) && $past(flag_r))
		else $error("loop interrupt without enable");

	a_auto_off_block: assert property (
		(!auto_r && read_i && !ack_r) |=> !clockgen_irq_out_o && !readdata_o[`LC_FLAG_BIT])
		else $error("loop flag visible with automatic mode off");

	a_bcs_unlocked: assert property (
		(wr_ctrl && wd[`LC_BCS_BIT] && pwr_r && !lock_seen) |=> bcs_r)
		else $error("select refused while unlocked");

	a_regs_by_write: assert property (
		!wr_ctrl |=> $stable(ie_r) && $stable(bcs_r) && $stable(pwr_r))
		else $error("control changed without a write");

	a_stop_all_low: assert property (
		(stop_i && !osc_run_r) [*2] |-> !crystal_clock_o && !base_clock_out_o
			&& !clockgen_irq_out_o && !loop_enable_o && !osc_enable_o)
		else $error("clock generator active in stop");

	a_stop_osc_runs: assert property (
		(stop_i && osc_run_r) |-> osc_enable_o && !loop_enable_o)
		else $error("oscillator stopped or loop on in stop");

	a_break_clear_ok: assert property (
		(wr_stat && break_i && break_flag_clear_enable_i && wd[0] && !lock_evt)
			|=> !st_r[`ST_LOCK_BIT])
		else $error("status clear lost during break");

	a_break_keeps: assert property (
		(protect && flag_r) |=> flag_r)
		else $error("loop flag lost during protected break");

	a_pwr_kept: assert property (
		(wr_ctrl && bcs_r) |=> pwr_r)
		else $error("loop powered down while selected");

	a_read_clears: assert property (
		(rd_ctrl && readdata_o[`LC_FLAG_BIT] && !protect && !lock_evt)
			|=> !flag_r ##1 !clockgen_irq_out_o)
		else $error("read did not clear the loop flag");

	c_lock_event: cover property (lock_evt && ie_r ##2 clockgen_irq_out_o);
	c_switch_done: cover property (sw_busy ##[1:200] sw_done);
	c_stop_osc: cover property (stop_i && osc_run_r);
	c_break_read: cover property (rd_ctrl && protect && flag_r);

endmodule // pll_lock_irq_and_lowpower_ctrl

// File: tb/loop_model.sv
// Behavioural model of the analog loop and crystal oscillator beside the block
module loop_model (
	// Clock
	input  wire logic clk_i,
	// Enables from the block and lock wish from the bench
	input  wire logic loop_enable_i,
	input  wire logic osc_enable_i,
	input  wire logic lock_want_i,
	// Analog side outputs
	output logic      lock_raw_o,
	output logic      crystal_clock_o,
	output logic      vco_clock_o
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		lock_raw_o = 1'b0;
		crystal_clock_o = 1'b0;
		vco_clock_o = 1'b0;
	end

	// ============================================================
	// Sources stand still low while powered down, as a dead oscillator would
	always @(posedge clk_i) begin
		crystal_clock_o <= osc_enable_i ? ~crystal_clock_o : 1'b0;
		vco_clock_o <= loop_enable_i ? ~vco_clock_o : 1'b0;
		lock_raw_o <= loop_enable_i & lock_want_i;
	end
endmodule // loop_model

// File: tb/tb.sv
// Self-checking testbench of the loop lock interrupt and low-power control block
`include "pll_ctrl_map.svh"

module tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [4:0]  addr = 5'h00;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [3:0]  be = 4'hf;
	logic [31:0] wdata = 32'h0;
	logic        stop = 1'b0;
	logic        brk = 1'b0;
	logic        break_flag_clear_enable = 1'b0;
	logic        lock_want = 1'b0;
	logic [31:0] rdata;
	logic        wreq, loop_en, osc_en, xclk_out, base_out, cg_irq, irq;
	logic        lock_raw, xclk, vclk, b0;
	logic [7:0]  q, m;
	logic [31:0] seed = 32'hae45192c;
	int          num_errors = 0;
	int          checks_done = 0;

	always #50 clk_i = ~clk_i;

	pll_lock_irq_and_lowpower_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .address_i(addr),
		.read_i(rd), .write_i(wr), .byteenable_i(be), .writedata_i(wdata),
		.readdata_o(rdata), .waitrequest_o(wreq), .lock_raw_i(lock_raw),
		.crystal_clock_i(xclk), .vco_clock_i(vclk), .loop_enable_o(loop_en),
		.osc_enable_o(osc_en), .crystal_clock_o(xclk_out), .base_clock_out_o(base_out),
		.stop_i(stop), .break_i(brk), .break_flag_clear_enable_i(break_flag_clear_enable),
		.clockgen_irq_out_o(cg_irq), .irq_o(irq));

	loop_model far_end (.clk_i(clk_i), .loop_enable_i(loop_en), .osc_enable_i(osc_en),
		.lock_want_i(lock_want), .lock_raw_o(lock_raw), .crystal_clock_o(xclk),
		.vco_clock_o(vclk));

	// ============================================================
	// Helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Sample before each edge so waitrequest and read data are settled
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
		output logic [7:0] r);
		int n;
		logic wt;
		@(posedge clk_i);
		rd <= ~w;
		wr <= w;
		addr <= a;
		wdata <= {24'h0, d};
		n = 0;
		do begin
			@(negedge clk_i);
			wt = wreq;
			r = rdata[7:0];
			n++;
			@(posedge clk_i);
		end while (wt !== 1'b0 && n < 50);
		if (n >= 50) begin
			num_errors++;
			end_of_test();
		end
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task automatic rchk(input logic [4:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00, q);
		check(q, e);
	endtask

	task automatic wreg(input logic [4:0] a, input logic [7:0] d);
		bus(1'b1, a, d, q);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	task automatic do_reset;
		rst_i <= 1'b1;
		cyc(20);
		rst_i <= 1'b0;
	endtask

	task automatic pulse_lock(input logic v);
		@(posedge clk_i);
		lock_want <= v;
		cyc(4);
		@(negedge clk_i);
	endtask

	task automatic end_of_test;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ============================================================
	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		cyc(5000);
		num_errors++;
		end_of_test();
	end

	// ============================================================
	// Tests
	initial begin
		do_reset();
		rchk(`LOOP_CTRL_OFS, 8'h20);
		rchk(`BW_CTRL_OFS, 8'h00);
		rchk(`IRQ_STAT_OFS, 8'h00);
		rchk(5'h14, 8'h00);
		$display("test reset values done");
		pulse_lock(1'b1);
		rchk(`BW_CTRL_OFS, 8'h00);
		rchk(`LOOP_CTRL_OFS, 8'h20);
		check({7'h0, cg_irq}, 8'h00);
		wreg(`BW_CTRL_OFS, 8'h80);
		pulse_lock(1'b0);
		pulse_lock(1'b1);
		check({7'h0, cg_irq}, 8'h00);
		rchk(`BW_CTRL_OFS, 8'hc0);
		rchk(`LOOP_CTRL_OFS, 8'h60);
		rchk(`LOOP_CTRL_OFS, 8'h20);
		$display("test manual and auto mode done");
		wreg(`IRQ_STAT_OFS, 8'h03);
		wreg(`IRQ_MASK_OFS, 8'h01);
		wreg(`LOOP_CTRL_OFS, 8'ha0);
		pulse_lock(1'b0);
		check({7'h0, cg_irq}, 8'h01);
		check({7'h0, irq}, 8'h01);
		wreg(`IRQ_STAT_OFS, 8'h01);
		// Interrupt output is registered: one more edge after the clear lands
		@(posedge clk_i);
		@(negedge clk_i);
		check({7'h0, irq}, 8'h00);
		$display("test interrupt path done");
		@(posedge clk_i);
		brk <= 1'b1;
		pulse_lock(1'b1);
		rchk(`LOOP_CTRL_OFS, 8'he0);
		rchk(`LOOP_CTRL_OFS, 8'he0);
		wreg(`IRQ_STAT_OFS, 8'h01);
		rchk(`IRQ_STAT_OFS, 8'h01);
		break_flag_clear_enable <= 1'b1;
		rchk(`LOOP_CTRL_OFS, 8'he0);
		brk <= 1'b0;
		break_flag_clear_enable <= 1'b0;
		rchk(`LOOP_CTRL_OFS, 8'ha0);
		$display("test break protection done");
		pulse_lock(1'b0);
		rchk(`BW_CTRL_OFS, 8'h80);
		wreg(`IRQ_STAT_OFS, 8'h03);
		wreg(`LOOP_CTRL_OFS, 8'h30);
		// Hold begins one edge after the write, output lags one more
		cyc(2);
		@(negedge clk_i);
		b0 = base_out;
		repeat (3) begin
			@(negedge clk_i);
			check({7'h0, base_out}, {7'h0, b0});
		end
		rchk(`LOOP_CTRL_OFS, 8'h70);
		wreg(`LOOP_CTRL_OFS, 8'h10);
		rchk(`LOOP_CTRL_OFS, 8'h30);
		cyc(30);
		rchk(`IRQ_STAT_OFS, 8'h02);
		wreg(`LOOP_CTRL_OFS, 8'h20);
		// Let the switch back to the crystal finish before the loop stops
		cyc(12);
		wreg(`LOOP_CTRL_OFS, 8'h00);
		@(negedge clk_i);
		check({7'h0, loop_en}, 8'h00);
		$display("test base clock select done");
		do_reset();
		wreg(`BW_CTRL_OFS, 8'h80);
		wreg(`LOOP_CTRL_OFS, 8'ha0);
		pulse_lock(1'b1);
		check({7'h0, cg_irq}, 8'h01);
		rchk(`BW_CTRL_OFS, 8'hc0);
		wreg(`LOOP_CTRL_OFS, 8'hb0);
		@(posedge clk_i);
		stop <= 1'b1;
		cyc(2);
		repeat (2) begin
			@(negedge clk_i);
			check({3'h0, loop_en, osc_en, xclk_out, base_out, cg_irq}, 8'h00);
		end
		@(posedge clk_i);
		stop <= 1'b0;
		do_reset();
		wreg(`CFG_TWO_OFS, 8'h01);
		stop <= 1'b1;
		cyc(3);
		@(negedge clk_i);
		b0 = xclk_out;
		check({6'h0, loop_en, osc_en}, 8'h01);
		@(negedge clk_i);
		check({7'h0, b0 ^ xclk_out}, 8'h01);
		wreg(`CFG_TWO_OFS, 8'h00);
		rchk(`CFG_TWO_OFS, 8'h01);
		stop <= 1'b0;
		$display("test stop modes done");
		m = 8'h00;
		repeat (8) begin
			seed = lfsr(seed);
			be <= {3'h7, seed[8]};
			wreg(`IRQ_MASK_OFS, seed[7:0]);
			if (seed[8]) m = seed[7:0] & 8'h03;
			rchk(`IRQ_MASK_OFS, m);
		end
		$display("test random mask writes done");
		end_of_test();
	end
endmodule // tb
